// File: pkg/cga_pkg.sv
// shared constants and types for the counter gate and arming control
package cga_pkg;
	// register byte offsets on the axi4-lite bus
	localparam logic [7:0] CGA_CTRL_OFS   = 8'h00;
	localparam logic [7:0] CGA_GATE_OFS   = 8'h04;
	localparam logic [7:0] CGA_STATUS_OFS = 8'h08;
	localparam logic [7:0] CGA_RESULT_OFS = 8'h0c;
	localparam logic [7:0] CGA_CMD_OFS    = 8'h10;
	// control register fields
	localparam int CGA_CTRL_HOLD_BIT = 0;
	localparam int CGA_CTRL_FUNC_LSB = 1;
	localparam int CGA_CTRL_FUNC_W   = 3;
	// command register fields (write one to act)
	localparam int CGA_CMD_ARM_BIT   = 0;
	localparam int CGA_CMD_RESET_BIT = 1;
	// status register fields
	localparam int CGA_ST_ARMED_BIT  = 0;
	localparam int CGA_ST_GATE_BIT   = 1;
	localparam int CGA_ST_READY_BIT  = 2;
	localparam int CGA_ST_OVF_BIT    = 3;
	localparam int CGA_ST_HOLD_BIT   = 4;
	// gate interval limits and default, in microseconds
	localparam int CGA_GATE_MIN_US   = 100;
	localparam int CGA_GATE_MAX_US   = 1000000;
	localparam int CGA_GATE_DEF_US   = 1000000;
	localparam int CGA_CLK_MHZ       = 50;
	localparam int CGA_CYC_PER_US    = CGA_CLK_MHZ;
	// totalize overflow beyond eight decimal digits
	localparam int CGA_TOT_DIGITS    = 8;
	localparam logic [31:0] CGA_TOT_MAX = 32'h05f5e0ff;
	// measurement functions
	typedef enum logic [2:0]
	{
		CGA_FN_FREQ            = 3'h0,
		CGA_FN_PER             = 3'h1,
		CGA_FN_PERIOD_AVERAGED = 3'h2,
		CGA_FN_PULS            = 3'h3,
		CGA_FN_ITOT            = 3'h4,
		CGA_FN_GATED_TOTALIZE  = 3'h5
	} cga_func_t;
	// gate sequencer states, gray along idle-armed-open-done
	typedef enum logic [1:0]
	{
		CGA_ST_IDLE  = 2'b00,
		CGA_ST_ARMED = 2'b01,
		CGA_ST_OPEN  = 2'b11,
		CGA_ST_DONE  = 2'b10
	} cga_state_t;
endpackage

// File: rtl/cga_sync.sv
// two flip-flop synchroniser with edge output for the counter input pin
`timescale 1ns/1ns
module cga_sync
(
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic pin,
	output logic      level,
	output logic      rise
);
	logic meta;
	logic stage;
	logic prev;
	logic next_meta;
	logic next_stage;
	logic next_prev;

	// only the second stage is looked at, the first may be metastable
	always_comb
	begin
		next_meta  = pin;
		next_stage = meta;
		next_prev  = stage;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta  <= 1'b0;
			stage <= 1'b0;
			prev  <= 1'b0;
		end
		else
		begin
			meta  <= next_meta;
			stage <= next_stage;
			prev  <= next_prev;
		end
	end

	assign level = stage;
	assign rise  = stage & ~prev;
endmodule

// File: rtl/cga_top.sv
// counter gate and arming control with an axi4-lite register slave
`timescale 1ns/1ns
// Contract
// - continuous mode re-arms itself and reports every valid signal's result
// - hold mode waits for an arm, measures one signal, presents one result
// - display mode comes out of reset as continuous
// - gate interval times frequency, period averaged and gated totalize
// - gate accepts 100e-6 to 1 s, defaults 1 s, reads back
// - a measurement starts only when armed and a valid signal arrives
// - continuous mode: the first valid signal after re-arming opens the gate, new cycle
// - hold mode: from idle or done, gate stays shut until an arm or counter reset is received
// - result read before gate completes stalls the bus until done
// - counter reset command clears the counter and arms it
// - gated totalize opens on first signal, holds count, flags overflow
module cga_top
	import cga_pkg::*;
#(
	parameter int GATE_DEF_US = CGA_GATE_DEF_US
)
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        count_in,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             gate_open
);
	localparam logic [1:0] RESP_OK  = 2'b00;
	localparam logic [1:0] RESP_ERR = 2'b10;

	logic        in_rise;
	cga_state_t  state, next_state;
	logic        hold_mode, next_hold_mode;
	cga_func_t   func, next_func;
	logic [31:0] gate_us, next_gate_us;
	logic [31:0] gate_cnt, next_gate_cnt;
	logic [31:0] acc, next_acc;
	logic [31:0] result, next_result;
	logic        ovf, next_ovf;
	logic        ready, next_ready;
	logic        aw_held, next_aw_held;
	logic [7:0]  aw_addr, next_aw_addr;
	logic        w_held, next_w_held;
	logic [31:0] w_data, next_w_data;
	logic        bvalid, next_bvalid;
	logic [1:0]  bresp, next_bresp;
	logic        ar_held, next_ar_held;
	logic [7:0]  ar_addr, next_ar_addr;
	logic        rvalid, next_rvalid;
	logic [31:0] rdata, next_rdata;
	logic [1:0]  rresp, next_rresp;
	logic        do_write, cmd_arm, cmd_reset;
	logic        gate_end, gated_fn, read_stall;
	logic [31:0] gate_cycles;

	cga_sync u_sync
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.pin     (count_in),
		.level   (),
		.rise    (in_rise)
	);

	// a write completes once both address and data are held and no response waits
	assign do_write  = aw_held && w_held && !bvalid;
	assign cmd_arm   = do_write && (aw_addr == CGA_CMD_OFS) && w_data[CGA_CMD_ARM_BIT];
	assign cmd_reset = do_write && (aw_addr == CGA_CMD_OFS) && w_data[CGA_CMD_RESET_BIT];
	// gated functions use the programmed interval; period modes close on the next edge
	assign gated_fn  = (func == CGA_FN_FREQ) || (func == CGA_FN_PERIOD_AVERAGED)
		|| (func == CGA_FN_GATED_TOTALIZE);
	assign gate_cycles = gate_us * CGA_CYC_PER_US;
	assign gate_end  = gated_fn ? (gate_cnt >= gate_cycles - 32'h1) : in_rise;
	// a result read with no finished result waits
	assign read_stall = ar_held && (ar_addr == CGA_RESULT_OFS) && !ready;

	// register file and write channel
	always_comb
	begin
		next_aw_held   = aw_held;
		next_aw_addr   = aw_addr;
		next_w_held    = w_held;
		next_w_data    = w_data;
		next_bvalid    = bvalid;
		next_bresp     = bresp;
		next_hold_mode = hold_mode;
		next_func      = func;
		next_gate_us   = gate_us;
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
		end
		if (do_write)
		begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = RESP_OK;
			case (aw_addr)
				CGA_CTRL_OFS:
				begin
					next_hold_mode = w_data[CGA_CTRL_HOLD_BIT];
					next_func = cga_func_t'(w_data[CGA_CTRL_FUNC_LSB +: CGA_CTRL_FUNC_W]);
				end
				CGA_GATE_OFS:
				begin
					// out-of-range interval is refused with slverr
					if (w_data >= CGA_GATE_MIN_US && w_data <= CGA_GATE_MAX_US)
						next_gate_us = w_data;
					else
						next_bresp = RESP_ERR;
				end
				CGA_CMD_OFS:
					next_bresp = RESP_OK;
				default:
					next_bresp = RESP_ERR;
			endcase
		end
		if (bvalid && s_axi_bready)
			next_bvalid = 1'b0;
	end

	// read channel; status and result show the block's own state
	always_comb
	begin
		next_ar_held = ar_held;
		next_ar_addr = ar_addr;
		next_rvalid  = rvalid;
		next_rdata   = rdata;
		next_rresp   = rresp;
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_ar_held = 1'b1;
			next_ar_addr = s_axi_araddr;
		end
		if (ar_held && !rvalid && !read_stall)
		begin
			next_ar_held = 1'b0;
			next_rvalid  = 1'b1;
			next_rresp   = RESP_OK;
			next_rdata   = 32'h0;
			case (ar_addr)
				CGA_CTRL_OFS:
				begin
					next_rdata[CGA_CTRL_HOLD_BIT] = hold_mode;
					next_rdata[CGA_CTRL_FUNC_LSB +: CGA_CTRL_FUNC_W] = func;
				end
				CGA_GATE_OFS:
					next_rdata = gate_us;
				CGA_STATUS_OFS:
				begin
					next_rdata[CGA_ST_ARMED_BIT] = (state == CGA_ST_ARMED);
					next_rdata[CGA_ST_GATE_BIT]  = (state == CGA_ST_OPEN);
					next_rdata[CGA_ST_READY_BIT] = ready;
					next_rdata[CGA_ST_OVF_BIT]   = ovf;
					next_rdata[CGA_ST_HOLD_BIT]  = hold_mode;
				end
				CGA_RESULT_OFS:
					next_rdata = result;
				CGA_CMD_OFS:
					next_rdata = 32'h0;
				default:
					next_rresp = RESP_ERR;
			endcase
		end
		if (rvalid && s_axi_rready)
			next_rvalid = 1'b0;
	end

	// gate sequencer: arming, gate timing and result latching
	always_comb
	begin
		next_state    = state;
		next_gate_cnt = gate_cnt;
		next_acc      = acc;
		next_result   = result;
		next_ovf      = ovf;
		next_ready    = ready;
		// a completed result read in continuous mode hands the reading over
		if (rvalid && s_axi_rready && ar_addr == CGA_RESULT_OFS && !hold_mode)
			next_ready = 1'b0;
		case (state)
			CGA_ST_IDLE:
			begin
				// continuous mode arms itself, hold waits for a command
				if (!hold_mode || cmd_arm)
					next_state = CGA_ST_ARMED;
			end
			CGA_ST_ARMED:
			begin
				if (in_rise)
				begin
					next_state    = CGA_ST_OPEN;
					next_gate_cnt = 32'h0;
					next_acc      = 32'h1; // opening edge, or opening cycle, counts as one
					next_ovf      = 1'b0;
				end
			end
			CGA_ST_OPEN:
			begin
				next_gate_cnt = gate_cnt + 32'h1;
				// period modes count clock cycles, the others count edges; all saturate
				if (func == CGA_FN_PER || func == CGA_FN_PULS || in_rise)
				begin
					if (acc == CGA_TOT_MAX)
						next_ovf = 1'b1;
					else
						next_acc = acc + 32'h1;
				end
				// totalize without a gate stays open until a reset command
				if (func != CGA_FN_ITOT && gate_end)
				begin
					next_result = acc;
					next_ready  = 1'b1;
					next_state  = hold_mode ? CGA_ST_DONE : CGA_ST_IDLE;
				end
			end
			CGA_ST_DONE:
				// a reading is kept until armed; leaving hold mode resumes self-arming
				next_state = hold_mode ? CGA_ST_DONE : CGA_ST_IDLE;
			default:
				next_state = CGA_ST_IDLE;
		endcase
		// a hold-mode arm after a reading starts over
		if (state == CGA_ST_DONE && cmd_arm)
		begin
			next_state = CGA_ST_ARMED;
			next_ready = 1'b0;
		end
		// counter reset clears and arms, overriding everything else
		if (cmd_reset)
		begin
			next_state    = CGA_ST_ARMED;
			next_gate_cnt = 32'h0;
			next_acc      = 32'h0;
			next_result   = 32'h0;
			next_ovf      = 1'b0;
			next_ready    = 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state     <= CGA_ST_IDLE;
			hold_mode <= 1'b0;
			func      <= CGA_FN_FREQ;
			gate_us   <= GATE_DEF_US;
			{gate_cnt, acc, result, ovf, ready}               <= '0;
			{aw_held, aw_addr, w_held, w_data, bvalid, bresp} <= '0;
			{ar_held, ar_addr, rvalid, rdata, rresp}          <= '0;
		end
		else
		begin
			state     <= next_state;
			hold_mode <= next_hold_mode;
			func      <= next_func;
			gate_us   <= next_gate_us;
			gate_cnt  <= next_gate_cnt;
			acc       <= next_acc;
			result    <= next_result;
			ovf       <= next_ovf;
			ready     <= next_ready;
			aw_held   <= next_aw_held;
			aw_addr   <= next_aw_addr;
			w_held    <= next_w_held;
			w_data    <= next_w_data;
			bvalid    <= next_bvalid;
			bresp     <= next_bresp;
			ar_held   <= next_ar_held;
			ar_addr   <= next_ar_addr;
			rvalid    <= next_rvalid;
			rdata     <= next_rdata;
			rresp     <= next_rresp;
		end
	end

	// awready and wready are high while their holding slot is empty, arready while ar_held and rvalid are both low
	assign s_axi_awready = !aw_held;
	assign s_axi_wready  = !w_held;
	assign s_axi_arready = !ar_held && !rvalid;
	assign s_axi_bvalid  = bvalid;
	assign s_axi_bresp   = bresp;
	assign s_axi_rvalid  = rvalid;
	assign s_axi_rdata   = rdata;
	assign s_axi_rresp   = rresp;
	assign gate_open     = (state == CGA_ST_OPEN);

	sequence arm_cmd_s;
		cmd_arm && (state == CGA_ST_IDLE || state == CGA_ST_DONE);
	endsequence

	hold_gate_shut_a: assert property (@(posedge aclk) disable iff (!aresetn)
		hold_mode && (state == CGA_ST_IDLE || state == CGA_ST_DONE) && !cmd_arm && !cmd_reset |=> state == $past(state))
		else $error("hold mode left its wait without an arm");
	open_needs_arm_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(gate_open) |-> $past(state) == CGA_ST_ARMED && $past(in_rise))
		else $error("gate opened without arm and signal");
	cont_rearm_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!hold_mode && state == CGA_ST_IDLE && !cmd_reset |=> state == CGA_ST_ARMED)
		else $error("continuous mode did not rearm");
	cont_open_a: assert property (@(posedge aclk) disable iff (!aresetn)
		state == CGA_ST_ARMED && in_rise && !cmd_reset |=> gate_open)
		else $error("valid signal did not open gate");
	hold_single_a: assert property (@(posedge aclk) disable iff (!aresetn)
		hold_mode && state == CGA_ST_DONE && !cmd_arm && !cmd_reset |=> state == CGA_ST_DONE && ready)
		else $error("hold mode took a second reading");
	hold_arm_seq_a: assert property (@(posedge aclk) disable iff (!aresetn)
		hold_mode ##0 arm_cmd_s |=> state == CGA_ST_ARMED)
		else $error("arm not taken");
	reset_arm_a: assert property (@(posedge aclk) disable iff (!aresetn)
		cmd_reset |=> state == CGA_ST_ARMED && acc == 32'h0 && !ready && !ovf)
		else $error("reset did not clear and arm");
	latch_close_a: assert property (@(posedge aclk) disable iff (!aresetn)
		gate_open && gate_end && func != CGA_FN_ITOT && !cmd_reset |=> ready && result == $past(acc))
		else $error("result not latched at gate close");
	stall_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
		read_stall |=> !rvalid)
		else $error("result answered before ready");
	gate_range_a: assert property (@(posedge aclk) disable iff (!aresetn)
		gate_us >= CGA_GATE_MIN_US && gate_us <= CGA_GATE_MAX_US)
		else $error("gate interval out of range");
	tot_cap_a: assert property (@(posedge aclk) disable iff (!aresetn)
		acc <= CGA_TOT_MAX)
		else $error("totalize passed eight digits");
	gate_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(gate_open) && gated_fn && !$past(cmd_reset) |-> $past(gate_cnt) == $past(gate_cycles) - 32'h1)
		else $error("gate length wrong");
endmodule

// File: tb/cga_src.sv
// model of the external signal source feeding the counter input
`timescale 1ns/1ns
module cga_src
(
	input  wire logic       aclk,
	input  wire logic       en,
	input  wire logic [7:0] half,
	output logic            sig
);
	logic [7:0] cnt;

	// square wave of 2*half cycles; the bench keeps the period below the gate time
	always_ff @(posedge aclk)
	begin
		if (!en)
		begin
			sig <= 1'b0; // idle low outside bursts, so no stray edge is seen
			cnt <= 8'h00;
		end
		else if (cnt >= half - 8'h01)
		begin
			sig <= !sig;
			cnt <= 8'h00;
		end
		else
			cnt <= cnt + 8'h01;
	end
endmodule

// File: tb/cga_top_tb.sv
// self-checking bench for the counter gate and arming control
`timescale 1ns/1ns
module cga_top_tb;
	import cga_pkg::*;
	logic        aclk, aresetn, src_en;
	logic        count_in, gate_open;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	int          n_errors, checked, cycles, len;
	logic [31:0] d;
	logic [1:0]  r;
	cga_func_t   fn [3] = '{CGA_FN_FREQ, CGA_FN_PERIOD_AVERAGED, CGA_FN_GATED_TOTALIZE};
	cga_func_t   pf [2] = '{CGA_FN_PER, CGA_FN_PULS};

	// short default gate keeps each gated measurement at 5000 cycles
	cga_top #(.GATE_DEF_US(100)) i_cga_top
	(
		.aclk(aclk), .aresetn(aresetn), .count_in(count_in),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .gate_open(gate_open)
	);
	cga_src i_cga_src (.aclk(aclk), .en(src_en), .half(8'h0a), .sig(count_in));

	initial
	begin
		aclk = 1'b0;
		forever #10 aclk = !aclk;
	end

	// watchdog: a hang counts as a mismatch
	always @(posedge aclk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			n_errors++;
			wrap_up();
		end
	end

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic chk_rng(input string nm, input int lo, input int hi, input logic [31:0] got);
		checked++;
		if ($isunknown(got) || !(got >= lo && got <= hi))
		begin
			n_errors++;
			$display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, got);
		end
	endtask

	// write: address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= v;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok))
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	// read: no latency assumed, a stalled result read simply waits
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		v = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// gate must open within 200 cycles; its open length is returned
	task automatic gate_len(output int n);
		int w;
		w = 0;
		n = 0;
		while (!gate_open && w < 200)
		begin
			@(posedge aclk);
			w++;
		end
		chk("gate_opens", 32'h1, {31'h0, gate_open});
		while (gate_open)
		begin
			@(posedge aclk);
			n++;
		end
	endtask

	task automatic no_gate(input int n);
		logic seen;
		seen = 1'b0;
		repeat (n)
		begin
			@(posedge aclk);
			seen = seen | gate_open;
		end
		chk("gate_shut", 32'h0, {31'h0, seen});
	endtask

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial
	begin
		aresetn = 1'b0;
		src_en = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = 32'h0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = 8'h00;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		n_errors = 0;
		checked = 0;
		cycles = 0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rd(CGA_CTRL_OFS, d, r);
		chk("ctrl_reset", 32'h0, d);
		rd(CGA_GATE_OFS, d, r);
		chk("gate_reset", 32'd100, d);
		rd(CGA_STATUS_OFS, d, r);
		chk("status_reset", 32'h1, d & 32'h1f);
		no_gate(200);
		rd(8'h14, d, r);
		chk("unmapped_resp", 32'h2, {30'h0, r});
		wr(CGA_GATE_OFS, 32'd99, r);
		chk("gate_low_resp", 32'h2, {30'h0, r});
		wr(CGA_GATE_OFS, 32'd1000000, r);
		rd(CGA_GATE_OFS, d, r);
		chk("gate_max", 32'd1000000, d);
		wr(CGA_GATE_OFS, 32'd100, r);
		rd(CGA_GATE_OFS, d, r);
		chk("gate_min", 32'd100, d);
		// gated functions in continuous mode: 20-cycle source, 5000-cycle gate
		foreach (fn[i])
		begin
			wr(CGA_CTRL_OFS, {28'h0, fn[i], 1'b0}, r);
			src_en <= 1'b1;
			fork
				gate_len(len);
				rd(CGA_RESULT_OFS, d, r);
			join
			chk_rng("gate_cycles", 4999, 5001, len);
			chk_rng("edge_count", 249, 251, d);
			gate_len(len);
			src_en <= 1'b0;
			chk_rng("regate_cycles", 4999, 5001, len);
			rd(CGA_RESULT_OFS, d, r);
			chk_rng("regate_count", 249, 251, d);
		end
		// period modes: gate runs from one edge to the next, result in clock cycles
		foreach (pf[i])
		begin
			wr(CGA_CTRL_OFS, {28'h0, pf[i], 1'b0}, r);
			src_en <= 1'b1;
			fork
				gate_len(len);
				rd(CGA_RESULT_OFS, d, r);
			join
			src_en <= 1'b0;
			chk("period_gate", 32'd20, len);
			chk("period_cycles", 32'd20, d);
		end
		// single reading mode: one result, then shut until armed
		wr(CGA_CTRL_OFS, 32'h1, r);
		rd(CGA_STATUS_OFS, d, r);
		chk("status_hold", 32'h10, d & 32'h10);
		src_en <= 1'b1;
		gate_len(len);
		rd(CGA_RESULT_OFS, d, r);
		chk_rng("hold_count", 249, 251, d);
		no_gate(300);
		rd(CGA_STATUS_OFS, d, r);
		chk("hold_unarmed", 32'h0, d & 32'h3);
		wr(CGA_CMD_OFS, 32'h1, r);
		gate_len(len);
		chk_rng("rearm_gate", 4999, 5001, len);
		// totalize without a gate stays open until the counter reset command
		wr(CGA_CTRL_OFS, 32'h9, r);
		wr(CGA_CMD_OFS, 32'h1, r);
		repeat (100) @(posedge aclk);
		chk("itot_open", 32'h1, {31'h0, gate_open});
		src_en <= 1'b0;
		wr(CGA_CMD_OFS, 32'h2, r);
		chk("itot_reset", 32'h0, {31'h0, gate_open});
		rd(CGA_STATUS_OFS, d, r);
		chk("reset_armed", 32'h1, d & 32'h0f);
		rd(CGA_CMD_OFS, d, r);
		chk("cmd_reads_zero", 32'h0, d);
		wrap_up();
	end
endmodule
